// file: logic/sbsc_regs.svh
// Constants for the synchronous burst SRAM control block.
// Included by the package and the design modules; definitions only.
`ifndef SBSC_REGS_SVH
`define SBSC_REGS_SVH

// Array geometry: 512K words of two 9-bit lanes
`define SBSC_ADDR_W 19
`define SBSC_LANES 2
`define SBSC_LANE_DATA_W 8
`define SBSC_LANE_W 9

// Two-bit burst counter
`define SBSC_CNT_W 2
`define SBSC_CNT_ZERO 2'h0
`define SBSC_CNT_ONE 2'h1
`define SBSC_BURST_LSB 2

// Burst order strap: high or open selects interleaved
`define SBSC_MODE_INTERLEAVED 1'h1

`endif

// file: logic/sbsc_pkg.sv
// Types shared by the burst SRAM control modules.
// Assumes sbsc_regs.svh is on the include path.
package sbsc_pkg;
    `include "sbsc_regs.svh"

    // Gray-coded access state: idle -> read -> write
    typedef enum logic [1:0] {
        SBSC_IDLE  = 2'h0,
        SBSC_READ  = 2'h1,
        SBSC_WRITE = 2'h3
    } sbsc_state_t;
endpackage

// file: logic/sbsc_mem.sv
// Byte-lane storage array with registered read data.
// Assumes one clock; read returns the old word on a same-address write.
`timescale 1ns/1ps
`include "sbsc_regs.svh"
module sbsc_mem #(
    parameter int AW = `SBSC_ADDR_W,
    parameter int LANES = `SBSC_LANES,
    parameter int LW = `SBSC_LANE_W
) (
    input wire logic clk,
    input wire logic [LANES-1:0] we,
    input wire logic [AW-1:0] addr,
    input wire logic [LANES*LW-1:0] wdata,
    output logic [LANES*LW-1:0] rdata
);
    logic [LANES*LW-1:0] mem [0:(1<<AW)-1];

    // One process owns the array, so the lanes never count as rival drivers
    always_ff @(posedge clk) begin
        rdata <= mem[addr];
        for (int i = 0; i < LANES; i++) begin
            if (we[i]) begin
                mem[addr][i*LW +: LW] <= wdata[i*LW +: LW];
            end
        end
    end
endmodule // sbsc_mem

// file: logic/sbsc_top.sv
// Function
// R1: Lane select writes only with qualifier low
// R2: Global write strobe writes every lane
// R3: Controller drives qualifier low for lane writes
// R4: All synchronous inputs captured on rising edge
// R5: Advance low increments burst counter
// R6: Primary select active low, joins decision
// R7: Secondary select active high, joins decision
// R8: Tertiary select active low, joins decision
// R9: Processor strobe ignored while primary deselected
// R10: Output drive enable asynchronous, active low
// R11: First read clock from deselect stays undriven
// R12: Processor strobe loads address and counter
// R13: Processor strobe wins over controller strobe
// R14: Two-bit counter wraps inside four words
// R15: Static strap picks linear or interleaved
// R16: Outputs off on write, deselect, first clock
// R17: Controller strobe loads address and counter
// R18: Parity lines follow their lane's select
//
// Control and storage of a flow-through synchronous burst SRAM.
// Assumes all inputs are synchronous to CLK except OUTPUT_DRIVE_EN_N;
// the pad wires are resolved outside from the output enables.
`timescale 1ns/1ps
`include "sbsc_regs.svh"
module sbsc_top
    import sbsc_pkg::*;
#(
    parameter int ADDR_W = `SBSC_ADDR_W,
    parameter int LANES = `SBSC_LANES
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [LANES-1:0] BYTE_LANE_WRITE_SELECT_N,
    input wire logic GLOBAL_WRITE_STROBE_N,
    input wire logic BYTE_WRITE_QUALIFIER_N,
    input wire logic PRIMARY_CHIP_SELECT_N,
    input wire logic SECONDARY_CHIP_SELECT,
    input wire logic TERTIARY_CHIP_SELECT_N,
    input wire logic BURST_ADVANCE_N,
    input wire logic PROCESSOR_ADDRESS_STROBE_N,
    input wire logic CONTROLLER_ADDRESS_STROBE_N,
    input wire logic BURST_ORDER_SEL,
    input wire logic OUTPUT_DRIVE_EN_N,
    input wire logic [LANES*`SBSC_LANE_DATA_W-1:0] DATA_I,
    output logic [LANES*`SBSC_LANE_DATA_W-1:0] DATA_O,
    output logic DATA_OE,
    input wire logic [LANES-1:0] BIDIR_PARITY_PINS_I,
    output logic [LANES-1:0] BIDIR_PARITY_PINS_O,
    output logic BIDIR_PARITY_PINS_OE
);
    localparam int DW = `SBSC_LANE_DATA_W;
    localparam int LW = `SBSC_LANE_W;

    sbsc_state_t state_ff, nxt_state;
    logic [ADDR_W-1:0] base_ff, nxt_base;
    logic [`SBSC_CNT_W-1:0] start_ff, nxt_start;
    logic [`SBSC_CNT_W-1:0] cnt_ff, nxt_cnt;
    logic first_ff, nxt_first;
    logic mode_ff, nxt_mode;

    logic selected;
    logic processor_address_strobe_n_rec;
    logic controller_address_strobe_n_rec;
    logic strobe_rec;
    logic wr_ok;
    logic [LANES-1:0] lane_req;
    logic [LANES-1:0] lane_we;
    logic [`SBSC_CNT_W-1:0] burst_lo;
    logic [ADDR_W-1:0] mem_addr;
    logic [LANES*LW-1:0] wdata;
    logic [LANES*LW-1:0] rdata;
    logic drive;

    // Combined select decision
    assign selected = !PRIMARY_CHIP_SELECT_N // [R6]
                      && SECONDARY_CHIP_SELECT // [R7]
                      && !TERTIARY_CHIP_SELECT_N; // [R8]
    // Processor strobe only counts while the primary select is low
    assign processor_address_strobe_n_rec = !PROCESSOR_ADDRESS_STROBE_N && !PRIMARY_CHIP_SELECT_N; // [R9]
    assign controller_address_strobe_n_rec = !CONTROLLER_ADDRESS_STROBE_N && !processor_address_strobe_n_rec; // [R13] [R17]
    assign strobe_rec = processor_address_strobe_n_rec || controller_address_strobe_n_rec;

    // Lane write enables before qualification by the access state
    always_comb begin
        if (!GLOBAL_WRITE_STROBE_N) begin
            lane_req = '1; // [R2]
        end else if (!BYTE_WRITE_QUALIFIER_N) begin
            lane_req = ~BYTE_LANE_WRITE_SELECT_N; // [R1] [R18]
        end else begin
            lane_req = '0; // [R1]
        end
    end

    // A processor-strobe start is always a read; writes follow a cycle later
    assign wr_ok = strobe_rec ? (controller_address_strobe_n_rec && selected) : (state_ff != SBSC_IDLE);
    assign lane_we = wr_ok ? lane_req : '0;

    always_comb begin
        nxt_state = state_ff;
        nxt_base = base_ff;
        nxt_start = start_ff;
        nxt_cnt = cnt_ff;
        nxt_first = 1'b0;
        nxt_mode = BURST_ORDER_SEL;
        if (strobe_rec) begin
            if (!selected) begin
                nxt_state = SBSC_IDLE;
            end else begin
                nxt_base = ADDR; // [R12] [R17]
                nxt_start = ADDR[`SBSC_CNT_W-1:0]; // [R12] [R17]
                nxt_cnt = `SBSC_CNT_ZERO;
                nxt_state = (|lane_we) ? SBSC_WRITE : SBSC_READ;
                nxt_first = (state_ff == SBSC_IDLE) && !(|lane_we); // [R11]
            end
        end else if (state_ff != SBSC_IDLE) begin
            if (!BURST_ADVANCE_N) begin
                nxt_cnt = cnt_ff + `SBSC_CNT_ONE; // [R5] [R14]
            end
            nxt_state = (|lane_we) ? SBSC_WRITE : SBSC_READ;
        end
    end

    // Synchronous inputs act through these rising-edge flops, or reach the u_mem array's rising-edge registers directly
    always_ff @(posedge CLK) begin // [R4]
        if (!RST_N) begin
            state_ff <= SBSC_IDLE;
            base_ff <= '0;
            start_ff <= `SBSC_CNT_ZERO;
            cnt_ff <= `SBSC_CNT_ZERO;
            first_ff <= 1'b0;
            mode_ff <= `SBSC_MODE_INTERLEAVED;
        end else begin
            state_ff <= nxt_state;
            base_ff <= nxt_base;
            start_ff <= nxt_start;
            cnt_ff <= nxt_cnt;
            first_ff <= nxt_first;
            mode_ff <= nxt_mode;
        end
    end

    // Burst order; the strap is assumed static, so one cycle of lag is harmless
    always_comb begin
        if (mode_ff == `SBSC_MODE_INTERLEAVED) begin
            burst_lo = nxt_start ^ nxt_cnt; // [R15] [R14]
        end else begin
            burst_lo = nxt_start + nxt_cnt; // [R15] [R14]
        end
    end
    // Array is addressed with the value being registered, so read data is flow-through
    assign mem_addr = {nxt_base[ADDR_W-1:`SBSC_BURST_LSB], burst_lo};

    for (genvar i = 0; i < LANES; i++) begin : g_lane
        assign wdata[i*LW +: LW] = {BIDIR_PARITY_PINS_I[i], DATA_I[i*DW +: DW]}; // [R18]
        assign DATA_O[i*DW +: DW] = rdata[i*LW +: DW];
        assign BIDIR_PARITY_PINS_O[i] = rdata[i*LW+DW];
    end

    sbsc_mem #(
        .AW(ADDR_W),
        .LANES(LANES),
        .LW(LW)
    ) u_mem (
        .clk(CLK),
        .we(lane_we),
        .addr(mem_addr),
        .wdata(wdata),
        .rdata(rdata)
    );

    // Output enable is asynchronous; the state terms mask it off
    assign drive = !OUTPUT_DRIVE_EN_N // [R10]
                   && (state_ff == SBSC_READ) // [R16]
                   && !first_ff; // [R11]
    assign DATA_OE = drive;
    assign BIDIR_PARITY_PINS_OE = drive; // [R18]

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    a_global_write_all: assert property ( // [R2]
        (!GLOBAL_WRITE_STROBE_N && wr_ok) |-> (lane_we == {LANES{1'h1}}))
        else $error("global write did not enable every lane");
    a_lane_select_qual: assert property ( // [R1]
        (GLOBAL_WRITE_STROBE_N && wr_ok) |->
        (lane_we == (BYTE_WRITE_QUALIFIER_N ? '0 : ~BYTE_LANE_WRITE_SELECT_N)))
        else $error("lane write enables disagree with selects and qualifier");
    a_advance_step: assert property ( // [R5]
        (!strobe_rec && state_ff != SBSC_IDLE && !BURST_ADVANCE_N) |=>
        (cnt_ff == 2'(($past(cnt_ff) + `SBSC_CNT_ONE))))
        else $error("burst counter did not step on advance");
    a_counter_hold: assert property ( // [R14]
        (!strobe_rec && BURST_ADVANCE_N) |=> $stable(cnt_ff) && $stable(base_ff))
        else $error("burst address moved without advance");
    a_processor_address_strobe_n_ignored: assert property ( // [R9]
        (PRIMARY_CHIP_SELECT_N && CONTROLLER_ADDRESS_STROBE_N) |=>
        $stable(base_ff) && $stable(start_ff))
        else $error("processor strobe acted while primary select high");
    a_deselect_any: assert property ( // [R6]
        (strobe_rec && !selected) |=> (state_ff == SBSC_IDLE) ##1 !DATA_OE)
        else $error("strobe while deselected did not idle the outputs");
    a_processor_address_strobe_n_priority: assert property ( // [R13]
        (processor_address_strobe_n_rec && selected && !CONTROLLER_ADDRESS_STROBE_N) |->
        (lane_we == '0) ##1 (state_ff == SBSC_READ && cnt_ff == `SBSC_CNT_ZERO))
        else $error("controller strobe acted alongside processor strobe");
    a_strobe_load: assert property ( // [R12]
        (strobe_rec && selected) |=>
        (base_ff == $past(ADDR) && start_ff == $past(ADDR[`SBSC_CNT_W-1:0])))
        else $error("strobe did not load address and counter");
    a_first_masked: assert property ( // [R11]
        (strobe_rec && selected && state_ff == SBSC_IDLE && lane_we == '0) |=>
        !DATA_OE ##1 (DATA_OE == (!OUTPUT_DRIVE_EN_N && state_ff == SBSC_READ)))
        else $error("output drove during first read clock from deselect");
    a_write_hiz: assert property ( // [R16]
        (state_ff != SBSC_READ || OUTPUT_DRIVE_EN_N) |-> !DATA_OE && !BIDIR_PARITY_PINS_OE)
        else $error("outputs driven during write, deselect or disable");

    c_processor_address_strobe_n_burst: cover property (processor_address_strobe_n_rec && selected ##1 !BURST_ADVANCE_N [*3]);
    c_controller_address_strobe_n_write: cover property (controller_address_strobe_n_rec && selected && |lane_we ##1 state_ff == SBSC_WRITE);
    c_read_drive: cover property (first_ff ##1 DATA_OE);
    c_deselect: cover property (state_ff == SBSC_READ ##1 state_ff == SBSC_IDLE);
endmodule // sbsc_top

// file: testbench/sbsc_host_model.sv
// Controller-side model: resolves the shared data and parity pads.
// Assumes the bench sets drv/drv_en and sbsc_top supplies its outputs.
`timescale 1ns/1ps
module sbsc_host_model (
    input wire logic clk,
    input wire logic drv_en,
    input wire logic [17:0] drv,
    input wire logic [15:0] dev_d,
    input wire logic [1:0] dev_p,
    input wire logic dev_oe,
    input wire logic dev_p_oe,
    output logic [15:0] pad_d,
    output logic [1:0] pad_p
);
    logic [17:0] last_ff;
    always_ff @(posedge clk) begin
        last_ff <= {pad_p, pad_d};
    end
    // Undriven pads flip, so stale data never passes as a real read
    always_comb begin
        {pad_p, pad_d} = ~last_ff;
        if (drv_en) begin
            {pad_p, pad_d} = drv;
        end
        if (dev_oe) begin
            pad_d = dev_d;
        end
        if (dev_p_oe) begin
            pad_p = dev_p;
        end
    end
endmodule // sbsc_host_model

// file: testbench/sbsc_top_test.sv
// Self-checking bench for sbsc_top: bursts, lane writes, strobes, selects.
// Assumes sbsc_pkg, sbsc_top and sbsc_host_model are compiled first.
`timescale 1ns/1ps
module sbsc_top_test;
    localparam int AW = 6;
    logic clk, rst_n, gw_n, bwe_n, ce1_n, ce2, ce3_n, adv_n, processor_address_strobe_n_n, controller_address_strobe_n_n, mode, oe_n, drv_en, d_oe, p_oe;
    logic [AW-1:0] addr;
    logic [1:0] bw_n, p_i, p_o;
    logic [15:0] d_i, d_o;
    logic [17:0] drv;
    logic [15:0] m_d [0:63];
    logic [1:0] m_p [0:63];
    int mismatches, n_checks, cycles;
    sbsc_top #(.ADDR_W(AW)) u_sbsc_top (.CLK(clk), .RST_N(rst_n), .ADDR(addr),
        .BYTE_LANE_WRITE_SELECT_N(bw_n), .GLOBAL_WRITE_STROBE_N(gw_n), .BYTE_WRITE_QUALIFIER_N(bwe_n),
        .PRIMARY_CHIP_SELECT_N(ce1_n), .SECONDARY_CHIP_SELECT(ce2), .TERTIARY_CHIP_SELECT_N(ce3_n),
        .BURST_ADVANCE_N(adv_n), .PROCESSOR_ADDRESS_STROBE_N(processor_address_strobe_n_n), .CONTROLLER_ADDRESS_STROBE_N(controller_address_strobe_n_n),
        .BURST_ORDER_SEL(mode), .OUTPUT_DRIVE_EN_N(oe_n), .DATA_I(d_i), .DATA_O(d_o), .DATA_OE(d_oe),
        .BIDIR_PARITY_PINS_I(p_i), .BIDIR_PARITY_PINS_O(p_o), .BIDIR_PARITY_PINS_OE(p_oe));
    sbsc_host_model u_sbsc_host_model (.clk(clk), .drv_en(drv_en), .drv(drv), .dev_d(d_o), .dev_p(p_o),
        .dev_oe(d_oe), .dev_p_oe(p_oe), .pad_d(d_i), .pad_p(p_i));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [AW-1:0] baddr(input logic [AW-1:0] a, input logic [1:0] k);
        return {a[AW-1:2], mode ? (a[1:0] ^ k) : (a[1:0] + k)};
    endfunction
    // Deselecting strobe returns the device to idle; outputs must then stay off
    task automatic idle();
        controller_address_strobe_n_n = 0;
        ce2 = 0;
        oe_n = 0;
        step();
        {controller_address_strobe_n_n, ce1_n, ce2, ce3_n, gw_n, drv_en} = 6'h2A;
        step();
        chk("oe idle", 18'h0, {p_oe, d_oe});
    endtask
    task automatic wr(input logic [AW-1:0] a, input int n, input logic g, input logic [1:0] bw, input logic q,
        input logic [17:0] v);
        logic [1:0] mk;
        logic [AW-1:0] x;
        mk = !g ? 2'h3 : (!q ? ~bw : 2'h0);
        {controller_address_strobe_n_n, addr, gw_n, bw_n, bwe_n, drv_en, oe_n} = {1'b0, a, g, bw, q, 2'h3};
        for (int k = 0; k < n; k++) begin
            x = baddr(a, k[1:0]);
            drv = v + 18'(k);
            for (int i = 0; i < 2; i++) begin
                if (mk[i]) begin
                    m_d[x][8*i+:8] = drv[8*i+:8];
                    m_p[x][i] = drv[16+i];
                end
            end
            step();
            controller_address_strobe_n_n = 1;
            adv_n = (k == n - 1);
        end
        {gw_n, bwe_n, bw_n} = 4'hF;
        idle();
    endtask
    task automatic rd(input logic [AW-1:0] a, input int n);
        logic [AW-1:0] x;
        {processor_address_strobe_n_n, addr, oe_n} = {1'b0, a, 1'b0};
        for (int k = 0; k < n; k++) begin
            x = baddr(a, k[1:0]);
            step();
            chk("read data", {m_p[x], m_d[x]}, {p_o, d_o});
            chk("read oe", {2{k != 0}}, {p_oe, d_oe});
            processor_address_strobe_n_n = 1;
            adv_n = (k == n - 1);
        end
        oe_n = 1;
        #1 chk("oe async", 18'h0, {p_oe, d_oe});
        idle();
    endtask
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            wrap_up();
        end
    end
    initial begin
        {rst_n, gw_n, bwe_n, bw_n, ce1_n, ce2, ce3_n, adv_n, processor_address_strobe_n_n, controller_address_strobe_n_n, mode, oe_n, drv_en} = 14'h1EBA;
        {addr, drv} = '0;
        repeat (8) @(posedge clk);
        #1 rst_n = 1;
        wr(6'h05, 4, 0, 2'h3, 1, 18'h0A5A0);
        rd(6'h05, 5);
        wr(6'h08, 4, 0, 2'h3, 1, 18'h11110);
        wr(6'h08, 2, 1, 2'h2, 0, 18'h3C3C3);
        wr(6'h0A, 2, 1, 2'h0, 1, 18'h2AAAA);
        rd(6'h08, 4);
        for (int j = 0; j < 3; j++) begin
            {ce1_n, ce2, ce3_n} = {j == 0, j != 1, j == 2};
            {controller_address_strobe_n_n, gw_n, drv_en, addr, drv} = {3'h1, 6'h05, 18'h3FFFF};
            step();
            idle();
        end
        {processor_address_strobe_n_n, controller_address_strobe_n_n, gw_n, drv_en, addr, drv} = {4'h1, 6'h05, 18'h15555};
        step();
        // Processor strobe held low with primary select high must not end the read
        {ce1_n, controller_address_strobe_n_n, gw_n, drv_en, oe_n} = 5'h1C;
        step();
        chk("ignored strobe", 18'h3, {p_oe, d_oe});
        chk("strobe priority data", {m_p[5], m_d[5]}, {p_o, d_o});
        {ce1_n, processor_address_strobe_n_n} = 2'h1;
        idle();
        mode = 1;
        step();
        step();
        rd(6'h05, 4);
        wrap_up();
    end
endmodule // sbsc_top_test
